// File: common/tsc_map.svh
// Register map and timing constants for the trigger sample controller
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH
`define TSC_CTRL_OFF      12'h000
`define TSC_STATUS_OFF    12'h004
`define TSC_TARGET_OFF    12'h008
`define TSC_MASK_OFF      12'h00C
`define TSC_IRQ_STAT_OFF  12'h010
`define TSC_IRQ_MASK_OFF  12'h014
`define TSC_COUNT_OFF     12'h018
`define TSC_SAMPLE_OFF    12'h01C
`define TSC_SMPL_CNT_OFF  12'h020
// Control fields
`define TSC_CTRL_START    0
`define TSC_CTRL_STOP     1
`define TSC_CTRL_SMODE_LO 2
`define TSC_CTRL_SMODE_HI 4
`define TSC_CTRL_CMODE_LO 5
`define TSC_CTRL_CMODE_HI 6
`define TSC_CTRL_COMPR    7
`define TSC_CTRL_XTRIG    8
`define TSC_CTRL_IMPORT   9
`define TSC_CTRL_EXPORT   10
`define TSC_CTRL_CNT_EN   11
// Interrupt bits
`define TSC_IRQ_DONE      0
`define TSC_IRQ_SAMPLE    1
`define TSC_IRQ_TRIG      2
`define TSC_IRQ_W         3
`define TSC_COMPR_MAX     7'd64
`define TSC_TARGET_RST    16'h0001
`endif

// File: common/tsc_pkg.sv
// Types shared by the trigger sample controller
package tsc_pkg;
    typedef enum logic [2:0] {
        TSC_SM_NORMAL    = 3'b000,
        TSC_SM_QUAL_FILL = 3'b001,
        TSC_SM_QUAL_INTR = 3'b010,
        TSC_SM_ARMED     = 3'b011,
        TSC_SM_STATEM    = 3'b100
    } tsc_smode_e;
    typedef enum logic [1:0] {
        TSC_CM_EVENTS = 2'b00,
        TSC_CM_CYCLES = 2'b01,
        TSC_CM_WDOG   = 2'b10,
        TSC_CM_PULSE  = 2'b11
    } tsc_cmode_e;
    typedef enum logic [1:0] {
        TSC_ST_IDLE = 2'b00,
        TSC_ST_RUN  = 2'b01,
        TSC_ST_HOLD = 2'b10,
        TSC_ST_DONE = 2'b11
    } tsc_state_e;
    typedef struct packed {
        logic        start;
        logic        stop;
        tsc_smode_e  smode;
        tsc_cmode_e  cmode;
        logic        compress;
        logic        xtrig_en;
        logic        import_en;
        logic        export_en;
        logic        cnt_en;
    } tsc_ctrl_s;
endpackage

// File: rtl/tsc_trigger_sample.sv
// Trigger, counter and sample capture controller with APB registers
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tsc_map.svh"
module tsc_trigger_sample
    import tsc_pkg::*;
#(
    parameter int DW = 32,
    parameter int XN = 2,
    parameter int EN = 2,
    parameter int CW = 16
)(
    input  wire logic          clock,
    input  wire logic          resetn,
    input  wire logic          clk_en,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output var  logic [31:0]   prdata,
    output var  logic          pready,
    output var  logic          pslverr,
    input  wire logic [DW-1:0] probe,
    input  wire logic          trig_cond,
    input  wire logic [XN-1:0] xtrig_in,
    input  wire logic [EN-1:0] ext_trig_in,
    output var  logic          trig_out,
    output var  logic          sample_valid,
    output var  logic [DW-1:0] sample_data,
    output var  logic          cnt_zero,
    output var  logic          irq
);

// ---------------------------------------------------------------
// Registers
// ---------------------------------------------------------------
tsc_ctrl_s       ctrl;
logic [CW-1:0]   target;
logic [DW-1:0]   cmask;
logic [`TSC_IRQ_W-1:0] irq_stat;
logic [`TSC_IRQ_W-1:0] irq_mask;
logic [CW-1:0]   count;
tsc_state_e      state;
tsc_state_e      next_state;
logic [DW-1:0]   last_sample;
logic [6:0]      same_cnt;
logic [31:0]     smpl_cnt;
logic            trig_q;
logic            started;
logic [XN-1:0]   xs1;
logic [XN-1:0]   xs2;

function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
endfunction

// ---------------------------------------------------------------
// Bus decode
// ---------------------------------------------------------------
wire        acc      = psel & penable & clk_en;
wire        wr       = acc & pwrite;
wire        wr_ctrl  = wr & hit(paddr, `TSC_CTRL_OFF);
wire        wr_tgt   = wr & hit(paddr, `TSC_TARGET_OFF);
wire        wr_mask  = wr & hit(paddr, `TSC_MASK_OFF);
wire        wr_istat = wr & hit(paddr, `TSC_IRQ_STAT_OFF);
wire        wr_imask = wr & hit(paddr, `TSC_IRQ_MASK_OFF);
wire        mapped   = hit(paddr, `TSC_CTRL_OFF) | hit(paddr, `TSC_STATUS_OFF)
                     | hit(paddr, `TSC_TARGET_OFF) | hit(paddr, `TSC_MASK_OFF)
                     | hit(paddr, `TSC_IRQ_STAT_OFF) | hit(paddr, `TSC_IRQ_MASK_OFF)
                     | hit(paddr, `TSC_COUNT_OFF) | hit(paddr, `TSC_SAMPLE_OFF)
                     | hit(paddr, `TSC_SMPL_CNT_OFF);
wire        start_p  = wr_ctrl & pwdata[`TSC_CTRL_START];
wire        stop_p   = wr_ctrl & pwdata[`TSC_CTRL_STOP];

// ---------------------------------------------------------------
// Combined trigger
// ---------------------------------------------------------------
// Cross inputs from other domains pass a two-stage synchroniser
wire        xhit     = ctrl.xtrig_en & (|xs2);
wire        ehit     = ctrl.import_en & (|ext_trig_in);
// State-machine mode uses cross ids as extra terms; others qualify
wire        sm_mode  = (ctrl.smode == TSC_SM_STATEM);
wire        comb_trig = sm_mode ? (trig_cond | xhit | ehit)
                      : ((trig_cond & (~ctrl.xtrig_en | xhit)) | ehit);
wire        trig_rise = comb_trig & ~trig_q;
wire        running   = (state == TSC_ST_RUN);

// ---------------------------------------------------------------
// Complex counter termination
// ---------------------------------------------------------------
wire        tgt_zero = (target == '0);
wire        cnt_hit  = (count == target - CW'(1));
logic       term;
always_comb
begin
    term = 1'b0;
    if (!ctrl.cnt_en)
        term = trig_rise;
    else
        case (ctrl.cmode)
            TSC_CM_EVENTS: term = !tgt_zero & trig_rise & cnt_hit;
            TSC_CM_CYCLES: term = tgt_zero ? trig_rise
                                : (started & (count == target));
            TSC_CM_WDOG:   term = !tgt_zero & !comb_trig & cnt_hit;
            TSC_CM_PULSE:  term = !tgt_zero & comb_trig & cnt_hit;
            default:       term = 1'b0;
        endcase
end

logic [CW-1:0] next_count;
always_comb
begin
    next_count = count;
    case (ctrl.cmode)
        TSC_CM_EVENTS: if (trig_rise) next_count = count + CW'(1);
        TSC_CM_CYCLES: if (started | trig_rise) next_count = count + CW'(1);
        TSC_CM_WDOG:   next_count = comb_trig ? '0 : count + CW'(1);
        TSC_CM_PULSE:  next_count = comb_trig ? count + CW'(1) : '0;
        default:       next_count = count;
    endcase
end

// ---------------------------------------------------------------
// Sampling decisions
// ---------------------------------------------------------------
wire        qual     = (ctrl.smode == TSC_SM_QUAL_FILL)
                     | (ctrl.smode == TSC_SM_QUAL_INTR);
wire        armed    = (ctrl.smode == TSC_SM_ARMED);
wire        compr_on = ctrl.compress & !sm_mode & !qual & !armed;
wire [DW-1:0] diff   = (probe ^ last_sample) & ~cmask;
wire        changed  = |diff;
wire        forced   = (same_cnt == (`TSC_COMPR_MAX - 7'd1));
wire        take_qual  = running & qual & comb_trig;
wire        take_armed = running & armed & trig_rise;
wire        take_norm  = running & !qual & !armed
                       & (!compr_on | changed | forced);
wire        take     = take_qual | take_armed | take_norm;
wire        stop_run = running & term & !qual & !armed;
wire        qual_end = running & (ctrl.smode == TSC_SM_QUAL_FILL) & term;

always_comb
begin
    next_state = state;
    case (state)
        TSC_ST_IDLE: if (start_p) next_state = TSC_ST_RUN;
        TSC_ST_RUN:  if (stop_p) next_state = TSC_ST_DONE;
                     else if (stop_run | qual_end) next_state = TSC_ST_DONE;
        TSC_ST_HOLD: next_state = TSC_ST_DONE;
        TSC_ST_DONE: if (start_p) next_state = TSC_ST_RUN;
        default:     next_state = TSC_ST_IDLE;
    endcase
end

wire [`TSC_IRQ_W-1:0] ev = {trig_rise & running,
                            take,
                            (next_state == TSC_ST_DONE) & running};

// ---------------------------------------------------------------
// Read mux
// ---------------------------------------------------------------
wire [31:0] ctrl_rd = {20'h0_0000, ctrl.cnt_en, ctrl.export_en, ctrl.import_en,
                       ctrl.xtrig_en, ctrl.compress, ctrl.cmode, ctrl.smode, 2'b00};
wire [31:0] stat_rd = {29'h0000_0000, cnt_zero, state};
logic [31:0] rd_mux;
always_comb
begin
    rd_mux = 32'h0000_0000;
    if (hit(paddr, `TSC_CTRL_OFF))     rd_mux = ctrl_rd;
    if (hit(paddr, `TSC_STATUS_OFF))   rd_mux = stat_rd;
    if (hit(paddr, `TSC_TARGET_OFF))   rd_mux = 32'(target);
    if (hit(paddr, `TSC_MASK_OFF))     rd_mux = 32'(cmask);
    if (hit(paddr, `TSC_IRQ_STAT_OFF)) rd_mux = 32'(irq_stat);
    if (hit(paddr, `TSC_IRQ_MASK_OFF)) rd_mux = 32'(irq_mask);
    if (hit(paddr, `TSC_COUNT_OFF))    rd_mux = 32'(count);
    if (hit(paddr, `TSC_SAMPLE_OFF))   rd_mux = 32'(sample_data);
    if (hit(paddr, `TSC_SMPL_CNT_OFF)) rd_mux = smpl_cnt;
end

// ---------------------------------------------------------------
// Sequential logic
// ---------------------------------------------------------------
always_ff @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        xs1 <= '0;
        xs2 <= '0;
    end
    else if (clk_en)
    begin
        xs1 <= xtrig_in;
        xs2 <= xs1;
    end
end

always_ff @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        ctrl     <= '0;
        target   <= `TSC_TARGET_RST;
        cmask    <= '0;
        irq_mask <= '0;
    end
    else if (clk_en)
    begin
        if (wr_ctrl && state != TSC_ST_RUN)
        begin
            ctrl.smode     <= tsc_smode_e'(pwdata[`TSC_CTRL_SMODE_HI:`TSC_CTRL_SMODE_LO]);
            ctrl.cmode     <= tsc_cmode_e'(pwdata[`TSC_CTRL_CMODE_HI:`TSC_CTRL_CMODE_LO]);
            ctrl.compress  <= pwdata[`TSC_CTRL_COMPR];
            ctrl.xtrig_en  <= pwdata[`TSC_CTRL_XTRIG];
            ctrl.import_en <= pwdata[`TSC_CTRL_IMPORT];
            ctrl.export_en <= pwdata[`TSC_CTRL_EXPORT];
            ctrl.cnt_en    <= pwdata[`TSC_CTRL_CNT_EN];
        end
        if (wr_tgt)   target   <= pwdata[CW-1:0];
        if (wr_mask)  cmask    <= pwdata[DW-1:0];
        if (wr_imask) irq_mask <= pwdata[`TSC_IRQ_W-1:0];
    end
end

always_ff @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        state       <= TSC_ST_IDLE;
        count       <= '0;
        started     <= 1'b0;
        trig_q      <= 1'b0;
        last_sample <= '0;
        same_cnt    <= '0;
        smpl_cnt    <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
        state  <= next_state;
        trig_q <= comb_trig;
        if (start_p)
        begin
            count    <= '0;
            started  <= 1'b0;
            same_cnt <= '0;
            smpl_cnt <= 32'h0000_0000;
        end
        else if (running)
        begin
            count <= next_count;
            if (trig_rise) started <= 1'b1;
            if (take)
            begin
                last_sample <= probe;
                same_cnt    <= '0;
                smpl_cnt    <= smpl_cnt + 32'h0000_0001;
            end
            else
                same_cnt <= same_cnt + 7'd1;
        end
    end
end

always_ff @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        irq_stat     <= '0;
        irq          <= 1'b0;
        prdata       <= 32'h0000_0000;
        pready       <= 1'b0;
        pslverr      <= 1'b0;
        trig_out     <= 1'b0;
        sample_valid <= 1'b0;
        sample_data  <= '0;
        cnt_zero     <= 1'b1;
    end
    else if (clk_en)
    begin
        // Set wins over a simultaneous write-one clear
        irq_stat     <= (irq_stat & ~(wr_istat ? pwdata[`TSC_IRQ_W-1:0] : '0)) | ev;
        irq          <= |(((irq_stat & ~(wr_istat ? pwdata[`TSC_IRQ_W-1:0] : '0)) | ev)
                         & irq_mask);
        pready       <= psel & !penable;
        pslverr      <= psel & !penable & !mapped;
        prdata       <= (psel & !penable & !pwrite) ? rd_mux : prdata;
        trig_out     <= ctrl.export_en & comb_trig;
        sample_valid <= take;
        if (take) sample_data <= probe;
        cnt_zero     <= (next_count == '0) | start_p;
    end
end

endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking testbench for the trigger sample controller
`timescale 1ns/10ps
`default_nettype none
`include "tsc_map.svh"
module tb_top
    import tsc_pkg::*;
;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [1:0]  xtrig_in = 2'h0;
    logic [1:0]  ext_trig_in = 2'h0;
    logic [1:0]  pat = 2'h0;
    logic [31:0] step = 32'h0000_0000;
    logic [31:0] prdata, sample_data, probe, rd;
    logic        pready, pslverr, trig_out, sample_valid, cnt_zero, irq, trig_cond, perr;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          n_smp = 0;
    int          cyc = 0;
    localparam logic [13:0] CT [5] = '{{2'd0, 8'd8, 2'd2, 2'd2}, {2'd1, 8'd0, 2'd0, 2'd1},
        {2'd1, 8'd20, 2'd2, 2'd0}, {2'd2, 8'd4, 2'd2, 2'd0}, {2'd3, 8'd4, 2'd2, 2'd1}};
    localparam logic [20:0] QT [3] = '{{3'd2, 8'd16, 8'd22, 2'd1},
        {3'd3, 8'd1, 8'd1, 2'd1}, {3'd1, 8'd0, 8'd2, 2'd3}};
    localparam logic [11:0] TT [5] = '{{5'b11000, 2'd1, 2'd0, 2'd0, 1'b1},
        {5'b10000, 2'd1, 2'd0, 2'd0, 1'b0}, {5'b11010, 2'd1, 2'd0, 2'd0, 1'b0},
        {5'b11010, 2'd1, 2'd3, 2'd0, 1'b1}, {5'b11100, 2'd0, 2'd0, 2'd3, 1'b1}};

    tsc_trigger_sample dut (.clock(clock), .resetn(resetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .probe(probe), .trig_cond(trig_cond),
        .xtrig_in(xtrig_in), .ext_trig_in(ext_trig_in), .trig_out(trig_out),
        .sample_valid(sample_valid), .sample_data(sample_data), .cnt_zero(cnt_zero), .irq(irq));
    tsc_dut_logic u_src (.clock(clock), .resetn(resetn), .pat(pat), .step(step),
        .probe(probe), .trig_cond(trig_cond));

    initial
    begin
        forever #25 clock = ~clock;
    end

    always @(posedge clock)
    begin
        n_smp = n_smp + ((sample_valid === 1'b1) ? 1 : 0);
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Bus access and comparison helpers
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1 && ++t < 50);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    task automatic chkr(input int v, input int lo, input int hi);
        chk(32'((v >= lo) && (v <= hi)), 32'h0000_0001);
    endtask

    function automatic logic [31:0] cfg(input logic [2:0] sm, input logic [1:0] cm,
        input logic [4:0] f);
        return {20'h0_0000, f, cm, sm, 2'b00};
    endfunction

    task automatic run(input logic [31:0] c);
        apb(1'b1, `TSC_CTRL_OFF, 32'h0000_0002);
        apb(1'b1, `TSC_CTRL_OFF, c);
        apb(1'b1, `TSC_CTRL_OFF, c | 32'h0000_0001);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        apb(1'b0, `TSC_STATUS_OFF, 32'h0000_0000);
        chk(rd, 32'h0000_0004);
        apb(1'b0, `TSC_TARGET_OFF, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        apb(1'b0, 12'h040, 32'h0000_0000);
        chk({31'h0, perr}, 32'h0000_0001);
    endtask

    task automatic t_counter();
        foreach (CT[i])
        begin
            apb(1'b1, `TSC_TARGET_OFF, {24'h0, CT[i][11:4]});
            run(cfg(TSC_SM_NORMAL, CT[i][13:12], 5'b10000));
            chk({31'h0, cnt_zero}, 32'h0000_0001);
            pat <= CT[i][3:2];
            repeat (10) @(posedge clock);
            apb(1'b0, `TSC_STATUS_OFF, 32'h0000_0000);
            chk({30'h0, rd[1:0]}, 32'h0000_0001);
            pat <= CT[i][1:0];
            repeat (16) @(posedge clock);
            apb(1'b0, `TSC_STATUS_OFF, 32'h0000_0000);
            chk({30'h0, rd[1:0]}, 32'h0000_0003);
            pat <= 2'h0;
        end
    endtask

    task automatic t_irq();
        apb(1'b1, `TSC_IRQ_MASK_OFF, 32'h0000_0001);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h0000_0001);
        apb(1'b1, `TSC_IRQ_STAT_OFF, 32'h0000_0001);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, `TSC_IRQ_MASK_OFF, 32'h0000_0000);
    endtask

    task automatic t_compr();
        apb(1'b1, `TSC_MASK_OFF, 32'h0000_FFFF);
        run(cfg(TSC_SM_NORMAL, TSC_CM_EVENTS, 5'b00001));
        step <= 32'h0000_0001;
        n_smp = 0;
        repeat (140) @(posedge clock);
        chkr(n_smp, 2, 3);
        apb(1'b1, `TSC_CTRL_OFF, 32'h0000_0002);
        apb(1'b1, `TSC_MASK_OFF, 32'h0000_0000);
        run(cfg(TSC_SM_NORMAL, TSC_CM_EVENTS, 5'b00001));
        n_smp = 0;
        repeat (40) @(posedge clock);
        chkr(n_smp, 38, 41);
        step <= 32'h0000_0000;
    endtask

    task automatic t_qual();
        foreach (QT[i])
        begin
            run(cfg(QT[i][20:18], TSC_CM_EVENTS, 5'b00000));
            n_smp = 0;
            pat <= 2'h1;
            repeat (20) @(posedge clock);
            chkr(n_smp, int'(QT[i][17:10]), int'(QT[i][9:2]));
            apb(1'b0, `TSC_STATUS_OFF, 32'h0000_0000);
            chk({30'h0, rd[1:0]}, {30'h0, QT[i][1:0]});
            pat <= 2'h0;
        end
    endtask

    task automatic t_trig();
        apb(1'b1, `TSC_TARGET_OFF, 32'h0000_0064);
        foreach (TT[i])
        begin
            run(cfg(TSC_SM_NORMAL, TSC_CM_EVENTS, TT[i][11:7]));
            pat <= TT[i][6:5];
            xtrig_in <= TT[i][4:3];
            ext_trig_in <= TT[i][2:1];
            repeat (6) @(posedge clock);
            chk({31'h0, trig_out}, {31'h0, TT[i][0]});
            pat <= 2'h0;
            xtrig_in <= 2'h0;
            ext_trig_in <= 2'h0;
        end
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        t_reset();
        t_counter();
        t_irq();
        t_compr();
        t_qual();
        t_trig();
        stop_test();
    end
endmodule
bind tsc_trigger_sample tsc_trigger_sample_monitor #(.DW(DW), .XN(XN), .EN(EN)) u_mon (
    .clock(clock), .resetn(resetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .probe(probe), .trig_cond(trig_cond), .xtrig_in(xtrig_in), .ext_trig_in(ext_trig_in),
    .trig_out(trig_out), .sample_valid(sample_valid), .sample_data(sample_data),
    .cnt_zero(cnt_zero), .irq(irq));
`default_nettype wire

// File: verification/tsc_dut_logic.sv
// Model of the probed logic that supplies probe values and the trigger level
`timescale 1ns/10ps
`default_nettype none
module tsc_dut_logic (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [1:0]  pat,
    input  wire logic [31:0] step,
    output var  logic [31:0] probe,
    output var  logic        trig_cond
);
    // Probe advances by step; trigger is low, high or toggling per pat
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            probe     <= 32'h0000_0000;
            trig_cond <= 1'b0;
        end
        else
        begin
            probe     <= probe + step;
            trig_cond <= (pat == 2'h2) ? ~trig_cond : pat[0];
        end
    end
endmodule
`default_nettype wire

// File: verification/tsc_trigger_sample_monitor.sv
// Checker for the trigger sample controller ports
`timescale 1ns/10ps
`default_nettype none
module tsc_trigger_sample_monitor #(
    parameter int DW = 32,
    parameter int XN = 2,
    parameter int EN = 2
)(
    input wire logic          clock,
    input wire logic          resetn,
    input wire logic          clk_en,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   pwdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic [DW-1:0] probe,
    input wire logic          trig_cond,
    input wire logic [XN-1:0] xtrig_in,
    input wire logic [EN-1:0] ext_trig_in,
    input wire logic          trig_out,
    input wire logic          sample_valid,
    input wire logic [DW-1:0] sample_data,
    input wire logic          cnt_zero,
    input wire logic          irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    sequence setup_s;
        clk_en && psel && !penable;
    endsequence
    sequence wr_s(a);
        setup_s ##1 (psel && penable && pwrite && paddr == a);
    endsequence
    AST_APB_ANSWER: assert property (setup_s |=> pready)
        else $error("no zero wait answer");
    AST_APB_PULSE: assert property (clk_en && pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_UNMAPPED: assert property (setup_s ##0 paddr > 12'h020 |=> pready && pslverr)
        else $error("unmapped access not refused");
    AST_MAPPED: assert property (setup_s ##0 paddr <= 12'h020 && paddr[1:0] == 2'b00
        |=> !pslverr)
        else $error("mapped access refused");
    AST_CNT_ZERO_RST: assert property (!$past(resetn) |-> cnt_zero)
        else $error("counter not zero after reset");
    AST_START_CLEARS: assert property (wr_s(12'h000) ##0 pwdata[0] |=> ##[0:1] cnt_zero)
        else $error("start did not clear counter");
    AST_IRQ_MASKED: assert property (wr_s(12'h014) ##0 pwdata[3:0] == 4'h0 |=> ##1 !irq)
        else $error("irq high with all masked");
    AST_SAMPLE_DATA: assert property (sample_valid |-> sample_data == $past(probe))
        else $error("stored sample differs from probe");
    AST_TRIG_OUT: assert property (trig_out |-> $past(trig_cond) || $past(|ext_trig_in)
        || $past(|xtrig_in, 2) || $past(|xtrig_in, 3))
        else $error("trigger out without cause");
endmodule
`default_nettype wire
